/* pmt_pkg.sv */
// Package for the period match timer: register map, fields, reset values.
// Assumes a plain register port with byte-wide data.
package pmt_pkg;
  localparam int PMT_ADDR_W = 2;
  localparam int PMT_DATA_W = 8;
  // ==========================================================================
  // Register offsets
  localparam logic [1:0] PMT_OFS_COUNT = 2'h0;
  localparam logic [1:0] PMT_OFS_PERIOD = 2'h1;
  localparam logic [1:0] PMT_OFS_CONTROL = 2'h2;
  localparam logic [1:0] PMT_OFS_STATUS = 2'h3;
  // ==========================================================================
  // Control and status fields
  localparam int PMT_CTL_PRE_LSB = 0;
  localparam int PMT_CTL_ON_BIT = 2;
  localparam int PMT_CTL_POST_LSB = 3;
  localparam int PMT_STA_FLAG_BIT = 0;
  localparam logic [7:0] PMT_CTL_WMASK = 8'h7F;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] PMT_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
  localparam logic [7:0] PMT_CTL_RST = 8'h00;
  // ==========================================================================
  // Prescale select codes and terminal counts
  localparam logic [1:0] PMT_PRE_DIV1 = 2'h0;
  localparam logic [1:0] PMT_PRE_DIV4 = 2'h1;
  localparam logic [3:0] PMT_PRE_TERM4 = 4'h3;
  localparam logic [3:0] PMT_PRE_TERM16 = 4'hF;
  // Oscillator divided by four gives the instruction tick
  localparam logic [1:0] PMT_OSC_TERM = 2'h3;
endpackage

/* pmt_prescaler.sv */
// Prescaler: divides instruction ticks by 1, 4 or 16.
// Assumes tick_in is a one-cycle pulse in the CLK_SYS domain.
module pmt_prescaler
  import pmt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [1:0] select,
  output logic tick_out
);
  logic [3:0] cnt_reg;
  logic [3:0] term;

  // ==========================================================================
  // Terminal count
  always_comb begin
    if (select == PMT_PRE_DIV1) begin
      term = '0;
    end else if (select == PMT_PRE_DIV4) begin
      term = PMT_PRE_TERM4;
    end else begin
      term = PMT_PRE_TERM16;
    end
  end

  // RULE2 prescale divide
  assign tick_out = tick_in && (cnt_reg == term);

  // RULE7 prescaler clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
    end else if (tick_in) begin
      cnt_reg <= (cnt_reg == term) ? 4'h0 : cnt_reg + 4'h1;
    end
  end
endmodule

/* pmt_postscaler.sv */
// Postscaler: counts matches, pulses once every select+1 matches.
// Assumes match_in is a one-cycle pulse.
module pmt_postscaler
  import pmt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic match_in,
  input wire logic [3:0] select,
  output logic done
);
  logic [3:0] cnt_reg;

  // RULE4 postscale ratio
  assign done = match_in && (cnt_reg == select);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
    end else if (match_in) begin
      cnt_reg <= done ? 4'h0 : cnt_reg + 4'h1;
    end
  end
endmodule

/* pmt_timer.sv */
// Period match timer top: 8-bit count, period compare, pre/postscaler.
// Assumes a synchronous register port, read data one cycle after strobe.
//
// Notes on behaviour
// RULE1 - While on, the count rises by one from 00h on each prescaled tick.
// RULE2 - Prescale field 00 divides by one, 01 by four, 1x by sixteen.
// RULE3 - Count equal to period gives a match, and the count is 00h next.
// RULE4 - Each match clocks a postscaler dividing by field value plus one.
// RULE5 - The interrupt request comes from the match through the postscaler.
// RULE6 - Reset clears the count and loads the period with FFh.
// RULE7 - Writes to count or control, and reset, clear both scalers.
// RULE8 - A control write leaves the count unchanged.
// RULE9 - Control bit 2 switches the timer on; zero stops counting.
// RULE10 - Control bit 7 ignores writes and reads as zero.
// RULE11 - Count and period are eight bits and read and write freely.
// RULE12 - The match is offered as a shift clock for the serial port.
// RULE13 - The interrupt flag sets on postscaler completion, stays until cleared.
//
// Our own choices: strobed register access and the register addresses.
module pmt_timer
  import pmt_pkg::*;
#(
  parameter int DATA_W = PMT_DATA_W
)
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [PMT_ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  output logic MATCH,
  output logic SHIFT_CLK,
  output logic IRQ
);
  logic [DATA_W-1:0] count_value_reg;
  logic [DATA_W-1:0] period_value_reg;
  logic [6:0] timer_control_reg;
  logic [1:0] osc_div_reg;
  logic irq_flag_reg;
  logic match_pend_reg;
  logic inst_tick;
  logic pre_tick;
  logic post_done;
  logic match_now;
  logic wr_count;
  logic wr_period;
  logic wr_ctl;
  logic wr_stat;
  logic scaler_clear;
  logic timer_on;
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;

  function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================================
  // Decode
  assign wr_count = WR && hit(ADDR, PMT_OFS_COUNT);
  assign wr_period = WR && hit(ADDR, PMT_OFS_PERIOD);
  assign wr_ctl = WR && hit(ADDR, PMT_OFS_CONTROL);
  assign wr_stat = WR && hit(ADDR, PMT_OFS_STATUS);
  assign timer_on = timer_control_reg[PMT_CTL_ON_BIT];
  assign prescale_select = timer_control_reg[PMT_CTL_PRE_LSB +: 2];
  assign postscale_select = timer_control_reg[PMT_CTL_POST_LSB +: 4];
  // RULE7 scaler clear
  assign scaler_clear = wr_count || wr_ctl;

  // ==========================================================================
  // Instruction tick: oscillator over four
  // RULE1 tick derivation
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      osc_div_reg <= '0;
    end else begin
      osc_div_reg <= osc_div_reg + 2'h1;
    end
  end
  // RULE9 on bit gates
  assign inst_tick = timer_on && (osc_div_reg == PMT_OSC_TERM);

  pmt_prescaler u_pre (
    .clk(CLK_SYS),
    .rst(RST),
    .clear(scaler_clear),
    .tick_in(inst_tick),
    .select(prescale_select),
    .tick_out(pre_tick)
  );

  // ==========================================================================
  // Compare: no match is taken in the cycle after a match, unless the count was written in the match cycle
  // RULE3 period compare
  assign match_now = timer_on && (count_value_reg == period_value_reg) &&
                     !match_pend_reg;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      match_pend_reg <= 1'b0;
    end else if (wr_count) begin
      match_pend_reg <= 1'b0;
    end else begin
      match_pend_reg <= match_now;
    end
  end

  // ==========================================================================
  // Count register
  // RULE6 count reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      count_value_reg <= PMT_COUNT_RST;
    end else if (wr_count) begin
      // RULE11 count write
      count_value_reg <= WDATA;
    end else if (match_now) begin
      // RULE3 reload zero
      count_value_reg <= PMT_COUNT_RST;
    end else if (pre_tick && !match_now) begin
      // RULE1 count advance
      count_value_reg <= count_value_reg + 8'h01;
    end
  end

  // RULE6 period reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      period_value_reg <= PMT_PERIOD_RST;
    end else if (wr_period) begin
      period_value_reg <= WDATA;
    end
  end

  // ==========================================================================
  // Control register; count untouched by this write
  // RULE8 count kept
  // RULE10 bit seven dropped
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      timer_control_reg <= PMT_CTL_RST[6:0];
    end else if (wr_ctl) begin
      timer_control_reg <= WDATA[6:0] & PMT_CTL_WMASK[6:0];
    end
  end

  pmt_postscaler u_post (
    .clk(CLK_SYS),
    .rst(RST),
    .clear(scaler_clear),
    .match_in(match_now),
    .select(postscale_select),
    .done(post_done)
  );

  // ==========================================================================
  // Sticky flag: a set in the clearing cycle wins
  // RULE13 sticky flag
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_flag_reg <= 1'b0;
    end else if (post_done) begin
      irq_flag_reg <= 1'b1;
    end else if (wr_stat && WDATA[PMT_STA_FLAG_BIT]) begin
      irq_flag_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs, all registered
  // RULE5 interrupt output
  // RULE12 shift clock
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      MATCH <= 1'b0;
      SHIFT_CLK <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      MATCH <= match_now;
      SHIFT_CLK <= match_now;
      IRQ <= irq_flag_reg || post_done;
    end
  end

  // RULE10 read zero
  // RULE11 register read
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      unique case (ADDR)
        PMT_OFS_COUNT: RDATA <= count_value_reg;
        PMT_OFS_PERIOD: RDATA <= period_value_reg;
        PMT_OFS_CONTROL: RDATA <= {1'b0, timer_control_reg};
        PMT_OFS_STATUS: RDATA <= {7'h00, irq_flag_reg};
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // ==========================================================================
  // Checks
  chk_reload_after_match: assert property ( // RULE3
    @(posedge CLK_SYS) disable iff (RST)
    match_now && !wr_count |=> count_value_reg == 8'h00)
    else $error("count not reloaded after match");

  chk_match_output: assert property ( // RULE12
    @(posedge CLK_SYS) disable iff (RST)
    match_now |=> MATCH && SHIFT_CLK)
    else $error("match not presented");

  chk_off_holds: assert property ( // RULE9
    @(posedge CLK_SYS) disable iff (RST)
    !timer_on && !wr_count && !match_pend_reg |=> $stable(count_value_reg))
    else $error("count moved while off");

  chk_count_step: assert property ( // RULE1
    @(posedge CLK_SYS) disable iff (RST)
    pre_tick && !match_now && !match_pend_reg && !wr_count
    |=> count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("count did not step");

  chk_ctl_keeps_count: assert property ( // RULE8
    @(posedge CLK_SYS) disable iff (RST)
    wr_ctl && !match_now && !pre_tick |=> $stable(count_value_reg))
    else $error("control write changed count");

  chk_flag_sticky: assert property ( // RULE13
    @(posedge CLK_SYS) disable iff (RST)
    post_done |=> irq_flag_reg ##1 IRQ)
    else $error("flag not set after postscale");

  chk_bit7_zero: assert property ( // RULE10
    @(posedge CLK_SYS) disable iff (RST)
    RD && ADDR == PMT_OFS_CONTROL |=> !RDATA[7])
    else $error("control bit 7 read as one");

  chk_scaler_clear: assert property ( // RULE7
    @(posedge CLK_SYS) disable iff (RST)
    wr_ctl && WDATA[PMT_CTL_POST_LSB +: 4] != 4'h0 |=> !post_done)
    else $error("postscaler not cleared");

  chk_count_write: assert property ( // RULE11
    @(posedge CLK_SYS) disable iff (RST)
    wr_count |=> count_value_reg == $past(WDATA))
    else $error("count write lost");

  chk_flag_holds: assert property ( // RULE13
    @(posedge CLK_SYS) disable iff (RST)
    irq_flag_reg && !wr_stat |=> irq_flag_reg)
    else $error("flag dropped without clear");

  chk_flag_clear: assert property ( // RULE13
    @(posedge CLK_SYS) disable iff (RST)
    wr_stat && WDATA[PMT_STA_FLAG_BIT] && !post_done |=> !irq_flag_reg)
    else $error("flag not cleared");

  chk_irq_follows: assert property ( // RULE5
    @(posedge CLK_SYS) disable iff (RST)
    irq_flag_reg |=> IRQ)
    else $error("request missing while flag set");

  chk_irq_source: assert property ( // RULE5
    @(posedge CLK_SYS) disable iff (RST)
    !irq_flag_reg && !post_done |=> !IRQ)
    else $error("request without source");

  chk_off_no_match: assert property ( // RULE9
    @(posedge CLK_SYS) disable iff (RST)
    !timer_on |=> !MATCH)
    else $error("match while off");

  chk_period_write: assert property ( // RULE11
    @(posedge CLK_SYS) disable iff (RST)
    wr_period |=> period_value_reg == $past(WDATA))
    else $error("period write lost");

  chk_period_holds: assert property ( // RULE11
    @(posedge CLK_SYS) disable iff (RST)
    !wr_period |=> $stable(period_value_reg))
    else $error("period moved without write");

  chk_rdata_idle: assert property ( // RULE11
    @(posedge CLK_SYS) disable iff (RST)
    !RD |=> RDATA == '0)
    else $error("read data outside read cycle");

  chk_match_single: assert property ( // RULE3
    @(posedge CLK_SYS) disable iff (RST)
    MATCH |=> !MATCH)
    else $error("match longer than one cycle");

  chk_tick_spacing: assert property ( // RULE1
    @(posedge CLK_SYS) disable iff (RST)
    inst_tick |=> !inst_tick ##1 !inst_tick ##1 !inst_tick)
    else $error("instruction tick too frequent");

  chk_pre_div1: assert property ( // RULE2
    @(posedge CLK_SYS) disable iff (RST)
    prescale_select == PMT_PRE_DIV1 |-> pre_tick == inst_tick)
    else $error("direct prescale dropped a tick");

  chk_post_one: assert property ( // RULE4
    @(posedge CLK_SYS) disable iff (RST)
    match_now && postscale_select == '0 |-> post_done)
    else $error("one to one postscale missed");

  chk_pre_clear: assert property ( // RULE7
    @(posedge CLK_SYS) disable iff (RST)
    scaler_clear && prescale_select != PMT_PRE_DIV1 |=> !pre_tick)
    else $error("prescaler not cleared");
endmodule

/* period_match_timer_tb.sv */
// Testbench for the period match timer: scaler table, then hand tests.
// Assumes pmt_pkg and pmt_timer are compiled first; one clock domain.
module period_match_timer_tb
  import pmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals and table
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic match;
  logic shift_clk;
  logic irq;
  int bad_count = 0;
  int samples_checked = 0;
  typedef struct {
    logic [1:0] pre;
    logic [3:0] post;
    logic [7:0] per;
    logic [15:0] gap;
  } pmt_row_t;
  // Gap between matches is 4 * prescale * period once the count has wrapped
  pmt_row_t rows [4] = '{
    '{2'h0, 4'h0, 8'h05, 16'h0014},
    '{2'h1, 4'h3, 8'h03, 16'h0030},
    '{2'h2, 4'hF, 8'h02, 16'h0080},
    '{2'h3, 4'h7, 8'h01, 16'h0040}
  };

  always #25 clk_sys = ~clk_sys;

  pmt_timer dut (
    .CLK_SYS(clk_sys),
    .RST(rst),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .RDATA(rdata),
    .MATCH(match),
    .SHIFT_CLK(shift_clk),
    .IRQ(irq)
  );
  // ==========================================================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_sys);
    // Read data stands one cycle only
    #1 check(16'(rdata), 16'h0000);
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_rd(a, v);
    check(16'(v), 16'(exp));
  endtask

  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog, generous against about 3500 cycles of tests
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    int cyc;
    int t1;
    int t2;
    logic [7:0] a;
    logic [7:0] b;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(PMT_OFS_COUNT, 8'h00);
    rd_chk(PMT_OFS_PERIOD, 8'hFF);
    rd_chk(PMT_OFS_CONTROL, 8'h00);
    rd_chk(PMT_OFS_STATUS, 8'h00);
    foreach (rows[i]) begin
      reg_wr(PMT_OFS_CONTROL, 8'h00);
      reg_wr(PMT_OFS_PERIOD, rows[i].per);
      reg_wr(PMT_OFS_COUNT, 8'h00);
      reg_wr(PMT_OFS_STATUS, 8'h01);
      reg_wr(PMT_OFS_CONTROL, {1'b0, rows[i].post, 1'b1, rows[i].pre});
      n = 0;
      cyc = 0;
      t1 = 0;
      t2 = 0;
      while (n < rows[i].post + 3 && cyc < 4000) begin
        @(posedge clk_sys);
        #1 cyc++;
        check(16'(shift_clk), 16'(match));
        if (match === 1'b1) begin
          n++;
          check(16'(irq), 16'(n > rows[i].post));
          if (n == 2) t1 = cyc;
          if (n == 3) t2 = cyc;
        end
      end
      check(16'(t2 - t1), rows[i].gap);
    end
    // Flag is cleared only with the timer stopped, so no match can race it
    reg_wr(PMT_OFS_CONTROL, 8'h00);
    reg_wr(PMT_OFS_STATUS, 8'h01);
    @(posedge clk_sys);
    #1 check(16'(irq), 16'h0000);
    reg_wr(PMT_OFS_CONTROL, 8'hFF);
    rd_chk(PMT_OFS_CONTROL, 8'h7F);
    reg_wr(PMT_OFS_COUNT, 8'h2A);
    reg_wr(PMT_OFS_CONTROL, 8'h00);
    rd_chk(PMT_OFS_COUNT, 8'h2A);
    repeat (40) @(posedge clk_sys);
    rd_chk(PMT_OFS_COUNT, 8'h2A);
    reg_wr(PMT_OFS_PERIOD, 8'hA5);
    rd_chk(PMT_OFS_PERIOD, 8'hA5);
    reg_wr(PMT_OFS_PERIOD, 8'hFF);
    reg_wr(PMT_OFS_COUNT, 8'h10);
    reg_wr(PMT_OFS_CONTROL, 8'h04);
    // Strobes 32 cycles apart span exactly eight instruction ticks
    reg_rd(PMT_OFS_COUNT, a);
    repeat (29) @(posedge clk_sys);
    reg_rd(PMT_OFS_COUNT, b);
    check(16'(b - a), 16'h0008);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 check(16'(irq), 16'h0000);
    rd_chk(PMT_OFS_COUNT, 8'h00);
    rd_chk(PMT_OFS_PERIOD, 8'hFF);
    complete_run();
  end
endmodule
